// ---- hdl/sacu_map.svh ----
// Purpose: constants of the service access command unit
// Assumes: included by the package and the top module
// Notes:   offsets are byte addresses on the register bus
`ifndef SACU_MAP_SVH
`define SACU_MAP_SVH
`define SACU_OP_PPREG   8'h20
`define SACU_OP_DCFG    8'h40
`define SACU_OP_ERASE   8'h70
`define SACU_OP_MEM     8'h00
`define SACU_ENTRY      8'h00
`define SACU_BLK_FULL   8'h80
`define SACU_ONE        8'h01
`define SACU_CRC_POLY   8'h07
`define SACU_DACC_RST   8'h03
`define SACU_DACC_MASK  8'h8F
`define SACU_DCFG_MASK  8'h07
`define SACU_PP_MASK    8'h0A
`define SACU_LOCK_BIT   2
`define SACU_DBG_BIT    1
`define SACU_HALT_BIT   2
`define SACU_PMODE_BIT  0
`define SACU_PSEL_BIT   1
`define SACU_PHALT_BIT  3
`define SACU_A_DACC     8'h00
`define SACU_A_DCFG     8'h04
`define SACU_A_PP       8'h08
`define SACU_A_STAT     8'h0C
`define SACU_A_FLAG     8'h10
`define SACU_RESP_OK    2'b00
`define SACU_RESP_ERR   2'b10
`define SACU_INIT_CAP   2'h2
`define SACU_INIT_END   2'h3
`endif

// ---- hdl/sacu_pkg.sv ----
// Purpose: types and shared arithmetic of the command unit
// Assumes: sacu_map.svh holds all numeric constants
// Notes:   crc is the smbus packet error code, msb first
package sacu_pkg;
`include "sacu_map.svh"
   typedef logic [7:0] sacu_byte_t;
   typedef enum logic [3:0] {
      st_idle, st_addr, st_entry, st_opc, st_bank, st_madr,
      st_wdata, st_wpec, st_rdata, st_fwd, st_nack, st_commit
   } sacu_state_t;

   function automatic sacu_byte_t sacu_crc8(input sacu_byte_t c, input sacu_byte_t d);
      sacu_byte_t r;
      r = c ^ d;
      for (int i = 0; i < 8; i++) begin
         r = r[7] ? ((r << 1) ^ `SACU_CRC_POLY) : (r << 1);
      end
      return r;
   endfunction : sacu_crc8
endpackage : sacu_pkg

// ---- hdl/sacu_top.sv ----
// Purpose: maintenance command decoder and security gate
// Assumes: smbus byte engine and memories on mclk_i
// Notes:   parallel port pins are synchronised before use
`include "sacu_map.svh"
module sacu_top
   import sacu_pkg::*;
#(
   parameter int BLK_DEPTH = 128
) (
   input  wire logic              mclk_i,
   input  wire logic              rst_i,
   input  wire logic [7:0]        s_axi_awaddr_i,
   input  wire logic              s_axi_awvalid_i,
   output logic                   s_axi_awready_o,
   input  wire logic [31:0]       s_axi_wdata_i,
   input  wire logic [3:0]        s_axi_wstrb_i,
   input  wire logic              s_axi_wvalid_i,
   output logic                   s_axi_wready_o,
   output logic [1:0]             s_axi_bresp_o,
   output logic                   s_axi_bvalid_o,
   input  wire logic              s_axi_bready_i,
   input  wire logic [7:0]        s_axi_araddr_i,
   input  wire logic              s_axi_arvalid_i,
   output logic                   s_axi_arready_o,
   output logic [31:0]            s_axi_rdata_o,
   output logic [1:0]             s_axi_rresp_o,
   output logic                   s_axi_rvalid_o,
   input  wire logic              s_axi_rready_i,
   input  wire logic              smb_start_i,
   input  wire logic              smb_stop_i,
   input  wire logic              smb_rx_valid_i,
   input  wire sacu_pkg::sacu_byte_t smb_rx_byte_i,
   output logic                   smb_ack_o,
   input  wire logic              smb_tx_req_i,
   output sacu_pkg::sacu_byte_t   smb_tx_byte_o,
   output logic                   fwd_valid_o,
   output sacu_pkg::sacu_byte_t   fwd_byte_o,
   input  wire logic              cpu_sleep_i,
   output logic                   cpu_halt_o,
   output logic                   erase_o,
   input  wire logic              short_sense_pin_i,
   output logic [15:0]            mem_addr_o,
   output sacu_pkg::sacu_byte_t   mem_wdata_o,
   output logic                   mem_we_o,
   input  wire sacu_pkg::sacu_byte_t mem_rdata_i,
   input  wire logic [7:0]        parallel_byte_port_i,
   output logic [7:0]             parallel_byte_port_o,
   output logic                   parallel_byte_port_oe_n_o,
   input  wire logic              write_strobe_i,
   input  wire logic              read_strobe_i,
   input  wire logic              addr_byte_select_i,
   input  wire logic              addr_latch_strobe_i
);
   import sacu_pkg::*;

   localparam int IW = $clog2(BLK_DEPTH);

   sacu_state_t st_r;
   sacu_byte_t  buf_r [BLK_DEPTH];
   sacu_byte_t  crc_r, op_r, n_r, idx_r, tx_r, fwd_r;
   sacu_byte_t  dacc_r, dcfg_r, pp_r, mwd_r, hi_r, lo_r, ppo_r;
   logic [15:0] base_r, maddr_r;
   logic        rd_pend_r, fwd_v_r, mwe_r, service_r, entry_r;
   logic [1:0]  init_r, rdp_r;
   logic        ss1_r, ss2_r;
   logic [11:0] ps1_r, ps2_r;
   logic [3:0]  ps3_r;

   // command decode of the received byte
   wire         rxv     = smb_rx_valid_i;
   wire [7:0]   rb      = smb_rx_byte_i;
   wire         locked  = dacc_r[`SACU_LOCK_BIT];
   wire         dbg_ok  = dacc_r[`SACU_DBG_BIT];
   wire         halted  = dcfg_r[`SACU_HALT_BIT];
   wire         op_cfg  = (rb == `SACU_OP_PPREG) || (rb == `SACU_OP_DCFG);
   wire         op_er   = (rb == `SACU_OP_ERASE);
   wire         op_mem  = (rb == `SACU_OP_MEM) || rb[7];
   wire         op_hw   = op_cfg || op_er || op_mem;
   wire         cfg_ok  = service_r || (!locked && dbg_ok);
   wire         mem_ok  = !locked && (service_r || dbg_ok)
                          && !cpu_sleep_i && halted
                          && !pp_r[`SACU_PSEL_BIT];
   wire         take    = op_er ? service_r
                          : (op_cfg ? cfg_ok : (op_mem && mem_ok));
   wire         pass    = !take && (!op_hw || (!service_r && locked));
   wire         go_fwd  = pass && !cpu_halt_o;
   wire [7:0]   blk_n   = (rb[6:0] == 7'h00) ? `SACU_BLK_FULL : {1'b0, rb[6:0]};
   wire [7:0]   n_dec   = op_mem ? (rb[7] ? blk_n : `SACU_ONE)
                          : (op_cfg ? `SACU_ONE : 8'h00);
   wire [7:0]   idx_inc = 8'(idx_r + `SACU_ONE);
   wire         last    = (idx_inc == n_r);
   wire         rd_ok   = (st_r == st_wdata) && (idx_r == 8'h00) && (n_r != 8'h00);
   wire [7:0]   rsrc    = (op_r == `SACU_OP_PPREG) ? pp_r
                          : ((op_r == `SACU_OP_DCFG) ? dcfg_r : mem_rdata_i);
   wire [15:0]  mptr    = 16'(base_r + {8'h00, idx_r});
   wire         in_cmt  = (st_r == st_commit);
   wire         cmt_er  = in_cmt && (op_r == `SACU_OP_ERASE);
   wire         cmt_dc  = in_cmt && (op_r == `SACU_OP_DCFG);
   wire         cmt_pp  = in_cmt && (op_r == `SACU_OP_PPREG) && service_r;
   wire         cmt_mem = in_cmt && (op_r == `SACU_OP_MEM || op_r[7]);
   wire         ent_set = (st_r == st_entry) && rxv && (rb == `SACU_ENTRY);

   // parallel port: synchronised strobes and falling edges
   wire         par_en  = service_r && !locked && pp_r[`SACU_PSEL_BIT]
                          && pp_r[`SACU_PHALT_BIT] && dcfg_r[`SACU_PMODE_BIT];
   wire         wr_fall = par_en && ps3_r[0] && !ps2_r[8];
   wire         rd_fall = par_en && ps3_r[1] && !ps2_r[9];
   wire         al_fall = par_en && ps3_r[3] && !ps2_r[11];

   // smbus acknowledge decision for the byte on smb_rx_byte_i
   assign smb_ack_o = (st_r == st_nack || st_r == st_idle) ? 1'b0
                      : (st_r == st_opc) ? (take || go_fwd)
                      : (st_r == st_wpec) ? (rb == crc_r)
                      : 1'b1;

   // register bus slave
   logic        aw_v_r, w_v_r, bv_r, rv_r;
   logic [7:0]  aw_a_r;
   logic [31:0] w_d_r, rd_r;
   logic [3:0]  w_s_r;
   logic [1:0]  br_r, rr_r;
   wire         wr_go   = aw_v_r && w_v_r && !bv_r;
   wire         w_dacc  = wr_go && (aw_a_r == `SACU_A_DACC) && w_s_r[0];
   wire         w_flag  = wr_go && (aw_a_r == `SACU_A_FLAG) && w_s_r[0] && w_d_r[0];
   wire         w_hit   = (aw_a_r == `SACU_A_DACC) || (aw_a_r == `SACU_A_FLAG);
   wire [7:0]   ra      = s_axi_araddr_i;
   wire         r_hit   = (ra == `SACU_A_DACC) || (ra == `SACU_A_DCFG)
                          || (ra == `SACU_A_PP) || (ra == `SACU_A_STAT)
                          || (ra == `SACU_A_FLAG);
   wire [31:0]  stat_w  = {16'h0000, op_r, 4'h0, par_en, halted, locked, service_r};
   wire [31:0]  rmux    = (ra == `SACU_A_DACC) ? {24'h000000, dacc_r}
                          : (ra == `SACU_A_DCFG) ? {24'h000000, dcfg_r}
                          : (ra == `SACU_A_PP) ? {24'h000000, pp_r}
                          : (ra == `SACU_A_STAT) ? stat_w
                          : {31'h00000000, entry_r};

   assign s_axi_awready_o = !aw_v_r && !bv_r;
   assign s_axi_wready_o  = !w_v_r && !bv_r;
   assign s_axi_bvalid_o  = bv_r;
   assign s_axi_bresp_o   = br_r;
   assign s_axi_arready_o = !rv_r;
   assign s_axi_rvalid_o  = rv_r;
   assign s_axi_rdata_o   = rd_r;
   assign s_axi_rresp_o   = rr_r;

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         aw_v_r <= 1'b0;
         w_v_r  <= 1'b0;
         bv_r   <= 1'b0;
         aw_a_r <= 8'h00;
         w_d_r  <= 32'h00000000;
         w_s_r  <= 4'h0;
         br_r   <= `SACU_RESP_OK;
      end else begin
         if (s_axi_awvalid_i && s_axi_awready_o) begin
            aw_v_r <= 1'b1;
            aw_a_r <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o) begin
            w_v_r <= 1'b1;
            w_d_r <= s_axi_wdata_i;
            w_s_r <= s_axi_wstrb_i;
         end
         if (wr_go) begin
            aw_v_r <= 1'b0;
            w_v_r  <= 1'b0;
            bv_r   <= 1'b1;
            br_r   <= w_hit ? `SACU_RESP_OK : `SACU_RESP_ERR;
         end else if (bv_r && s_axi_bready_i) begin
            bv_r <= 1'b0;
         end
      end
   end

   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         rv_r <= 1'b0;
         rd_r <= 32'h00000000;
         rr_r <= `SACU_RESP_OK;
      end else if (s_axi_arvalid_i && !rv_r) begin
         rv_r <= 1'b1;
         rd_r <= r_hit ? rmux : 32'h00000000;
         rr_r <= r_hit ? `SACU_RESP_OK : `SACU_RESP_ERR;
      end else if (rv_r && s_axi_rready_i) begin
         rv_r <= 1'b0;
      end
   end

   // security registers
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         dacc_r  <= `SACU_DACC_RST;
         entry_r <= 1'b0;
      end else begin
         if (cmt_er) begin
            dacc_r <= `SACU_DACC_RST;
         end else if (w_dacc) begin
            dacc_r <= w_d_r[7:0] & `SACU_DACC_MASK;
         end
         if (ent_set) begin
            entry_r <= 1'b1;
         end else if (w_flag) begin
            entry_r <= 1'b0;
         end
      end
   end

   // service mode strap caught after reset release
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ss1_r     <= 1'b0;
         ss2_r     <= 1'b0;
         init_r    <= 2'h0;
         service_r <= 1'b0;
         dcfg_r    <= 8'h00;
         pp_r      <= 8'h00;
      end else begin
         ss1_r <= short_sense_pin_i;
         ss2_r <= ss1_r;
         if (init_r != `SACU_INIT_END) begin
            init_r <= 2'(init_r + 2'h1);
         end
         if (init_r == `SACU_INIT_CAP) begin
            service_r                <= ss2_r;
            dcfg_r[`SACU_HALT_BIT]   <= ss2_r;
         end else if (cmt_dc) begin
            dcfg_r <= {5'h00,
                       cpu_sleep_i ? dcfg_r[`SACU_HALT_BIT]
                                   : buf_r[0][`SACU_HALT_BIT],
                       buf_r[0][1:0]} & `SACU_DCFG_MASK;
         end
         if (cmt_pp) begin
            pp_r <= buf_r[0] & `SACU_PP_MASK;
         end
      end
   end

   // parallel port synchronisers and address latch
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         ps1_r <= 12'h000;
         ps2_r <= 12'h000;
         ps3_r <= 4'h0;
         hi_r  <= 8'h00;
         lo_r  <= 8'h00;
         rdp_r <= 2'h0;
         ppo_r <= 8'h00;
      end else begin
         ps1_r <= {addr_latch_strobe_i, addr_byte_select_i, read_strobe_i,
                   write_strobe_i, parallel_byte_port_i};
         ps2_r <= ps1_r;
         ps3_r <= ps2_r[11:8];
         if (al_fall && ps2_r[10]) begin
            hi_r <= ps2_r[7:0];
         end else if (al_fall) begin
            lo_r <= ps2_r[7:0];
         end
         rdp_r <= {rdp_r[0], rd_fall};
         if (rdp_r[1]) begin
            ppo_r <= mem_rdata_i;
         end
      end
   end

   assign parallel_byte_port_o      = ppo_r;
   assign parallel_byte_port_oe_n_o = !(par_en && !ps2_r[9]);
   assign cpu_halt_o                = halted || par_en;
   assign erase_o                   = cmt_er;
   assign fwd_valid_o               = fwd_v_r;
   assign fwd_byte_o                = fwd_r;
   assign smb_tx_byte_o             = tx_r;
   assign mem_addr_o                = maddr_r;
   assign mem_wdata_o               = mwd_r;
   assign mem_we_o                  = mwe_r;

   // command sequencer
   always_ff @(posedge mclk_i or posedge rst_i) begin
      if (rst_i) begin
         st_r      <= st_idle;
         crc_r     <= 8'h00;
         op_r      <= 8'h00;
         n_r       <= 8'h00;
         idx_r     <= 8'h00;
         tx_r      <= 8'h00;
         fwd_r     <= 8'h00;
         fwd_v_r   <= 1'b0;
         base_r    <= 16'h0000;
         rd_pend_r <= 1'b0;
         maddr_r   <= 16'h0000;
         mwd_r     <= 8'h00;
         mwe_r     <= 1'b0;
      end else begin
         fwd_v_r <= 1'b0;
         mwe_r   <= 1'b0;
         if (smb_start_i) begin
            rd_pend_r <= rd_ok;
            if (!rd_ok) begin
               crc_r <= 8'h00;
            end
            st_r <= st_addr;
         end else if (smb_stop_i && !in_cmt) begin
            st_r <= st_idle;
         end else if (rxv) begin
            if (st_r != st_wpec) begin
               crc_r <= sacu_crc8(crc_r, rb);
            end
            case (st_r)
               st_addr: begin
                  idx_r <= 8'h00;
                  st_r  <= rb[0] ? (rd_pend_r ? st_rdata : st_nack) : st_entry;
               end
               st_entry: begin
                  if (rb == `SACU_ENTRY) begin
                     st_r <= st_opc;
                  end else begin
                     st_r    <= cpu_halt_o ? st_nack : st_fwd;
                     fwd_v_r <= !cpu_halt_o;
                     fwd_r   <= rb;
                  end
               end
               st_opc: begin
                  op_r  <= rb;
                  n_r   <= n_dec;
                  idx_r <= 8'h00;
                  if (take) begin
                     st_r <= op_er ? st_wpec : (op_cfg ? st_wdata : st_bank);
                  end else if (go_fwd) begin
                     st_r    <= st_fwd;
                     fwd_v_r <= 1'b1;
                     fwd_r   <= rb;
                  end else begin
                     st_r <= st_nack;
                  end
               end
               st_bank: begin
                  base_r[15:8] <= rb;
                  st_r         <= st_madr;
               end
               st_madr: begin
                  base_r[7:0] <= rb;
                  st_r        <= st_wdata;
               end
               st_wdata: begin
                  buf_r[idx_r[IW-1:0]] <= rb;
                  idx_r                <= idx_inc;
                  if (last) begin
                     st_r <= st_wpec;
                  end
               end
               st_wpec: begin
                  idx_r <= 8'h00;
                  st_r  <= (rb == crc_r) ? st_commit : st_nack;
               end
               st_fwd: begin
                  fwd_v_r <= !cpu_halt_o;
                  fwd_r   <= rb;
               end
               default: begin
               end
            endcase
         end else if (st_r == st_rdata && smb_tx_req_i) begin
            if (idx_r < n_r) begin
               tx_r  <= rsrc;
               crc_r <= sacu_crc8(crc_r, rsrc);
               idx_r <= idx_inc;
            end else begin
               tx_r <= crc_r;
            end
         end else if (in_cmt) begin
            if (cmt_mem) begin
               mwe_r   <= 1'b1;
               maddr_r <= mptr;
               mwd_r   <= buf_r[idx_r[IW-1:0]];
               idx_r   <= idx_inc;
            end
            if (!cmt_mem || last) begin
               st_r <= st_idle;
            end
         end
         if (st_r == st_rdata) begin
            maddr_r <= mptr;
         end
         if (wr_fall || rd_fall) begin
            maddr_r <= {hi_r, lo_r};
         end
         if (wr_fall) begin
            mwe_r <= 1'b1;
            mwd_r <= ps2_r[7:0];
         end
      end
   end
endmodule : sacu_top

// ---- sim/sacu_sva.sv ----
// Purpose: port checks of the command unit
// Assumes: bound to sacu_top from the tb file
// Notes:   one clock domain, reset disables all
module sacu_sva (
   input wire logic        mclk_i,
   input wire logic        rst_i,
   input wire logic        s_axi_arvalid_i,
   input wire logic        s_axi_arready_o,
   input wire logic [7:0]  s_axi_araddr_i,
   input wire logic [31:0] s_axi_rdata_o,
   input wire logic [1:0]  s_axi_rresp_o,
   input wire logic        s_axi_rvalid_o,
   input wire logic        s_axi_rready_i,
   input wire logic [1:0]  s_axi_bresp_o,
   input wire logic        s_axi_bvalid_o,
   input wire logic        s_axi_bready_i,
   input wire logic        fwd_valid_o,
   input wire logic        cpu_halt_o,
   input wire logic        erase_o,
   input wire logic        short_sense_pin_i,
   input wire logic        parallel_byte_port_oe_n_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge mclk_i); endclocking
   default disable iff (rst_i);
   property p_b_hold;
      s_axi_bvalid_o && !s_axi_bready_i |=> s_axi_bvalid_o && $stable(s_axi_bresp_o);
   endproperty
   a_b_hold: assert property (p_b_hold) else $error("write answer dropped");
   property p_r_hold;
      s_axi_rvalid_o && !s_axi_rready_i |=> s_axi_rvalid_o && $stable(s_axi_rdata_o);
   endproperty
   a_r_hold: assert property (p_r_hold) else $error("read answer dropped");
   property p_ar_busy; s_axi_rvalid_o |-> !s_axi_arready_o; endproperty
   a_ar_busy: assert property (p_ar_busy) else $error("read taken while busy");
   property p_unmapped;
      s_axi_arvalid_i && s_axi_arready_o && s_axi_araddr_i > 8'h10
         |=> s_axi_rvalid_o && s_axi_rresp_o == 2'h2 && s_axi_rdata_o == 32'h0;
   endproperty
   a_unmapped: assert property (p_unmapped) else $error("unmapped read answer");
   property p_erase; erase_o |=> !erase_o; endproperty
   a_erase: assert property (p_erase) else $error("erase pulse too long");
   property p_oe_mode; !parallel_byte_port_oe_n_o |-> cpu_halt_o; endproperty
   a_oe_mode: assert property (p_oe_mode) else $error("port driven outside mode");
   property p_fwd_run; fwd_valid_o |-> !$past(cpu_halt_o); endproperty
   a_fwd_run: assert property (p_fwd_run) else $error("forward while halted");
   property p_strap;
      $fell(rst_i) |-> ##3 (cpu_halt_o == $past(short_sense_pin_i, 3));
   endproperty
   a_strap: assert property (p_strap) else $error("halt after reset wrong");
   c_erase: cover property (erase_o);
   c_fwd: cover property (fwd_valid_o);
   c_par: cover property (!parallel_byte_port_oe_n_o);
endmodule : sacu_sva

// ---- sim/sacu_host.sv ----
// Purpose: smbus master seen through the byte engine
// Assumes: one byte per call, pec kept across repeated start
// Notes:   released data shows the inverse of the last byte
module sacu_host (
   input  wire logic                 clk_i,
   input  wire logic                 ack_i,
   input  wire sacu_pkg::sacu_byte_t tx_i,
   output logic                      start_o,
   output logic                      stop_o,
   output logic                      rxv_o,
   output sacu_pkg::sacu_byte_t      rxb_o,
   output logic                      txr_o
);
   timeunit 1ns;
   timeprecision 1ps;
   import sacu_pkg::*;
   sacu_byte_t pec;
   logic       ack_q;
   int         gap = 1;
   initial begin
      {start_o, stop_o, rxv_o, txr_o, rxb_o} = 12'h0FF;
   end
   function automatic sacu_byte_t crc(input sacu_byte_t c, input sacu_byte_t d);
      for (int i = 7; i >= 0; i--) begin
         c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
      end
      return c;
   endfunction : crc
   task automatic cond(input logic is_stop);
      @(posedge clk_i);
      {start_o, stop_o} <= {!is_stop, is_stop};
      @(posedge clk_i);
      {start_o, stop_o} <= 2'b00;
   endtask : cond
   task automatic put(input sacu_byte_t b);
      @(posedge clk_i);
      {rxv_o, rxb_o} <= {1'b1, b};
      @(posedge clk_i);
      ack_q = ack_i;
      {rxv_o, rxb_o} <= {1'b0, ~b};
      pec = crc(pec, b);
      repeat (gap) @(posedge clk_i);
   endtask : put
   task automatic get(output sacu_byte_t b);
      repeat (2) @(posedge clk_i);
      txr_o <= 1'b1;
      @(posedge clk_i);
      txr_o <= 1'b0;
      @(posedge clk_i);
      b = tx_i;
      pec = crc(pec, b);
      repeat (gap) @(posedge clk_i);
   endtask : get
endmodule : sacu_host

// ---- sim/tb.sv ----
// Purpose: self-checking bench of the command unit
// Assumes: byte engine replaced by sacu_host, memory by an array
// Notes:   strap level chosen at each reset
module tb;
   timeunit 1ns;
   timeprecision 1ps;
   import sacu_pkg::*;
   logic        mclk_i = 1'b0, rst_i = 1'b1, strap = 1'b1, sleep = 1'b0;
   logic        awv = 1'b0, wv = 1'b0, bry = 1'b0, arv = 1'b0, rry = 1'b0;
   logic        wrs = 1'b1, rds = 1'b1, sel = 1'b0, ale = 1'b1;
   logic        awr, wry, bv, arr, rv, ack, fv, halt, ers, we, oen, st, sp, rxv, txr;
   logic [1:0]  br, rr;
   logic [7:0]  awa = 8'h00, ara = 8'h00, pin = 8'h00, rdat = 8'h00;
   logic [7:0]  pout, txb, fb, rxb, wd8;
   logic [15:0] ma;
   logic [31:0] wd = 32'h0, rd, xs = 32'd52165;
   logic [7:0]  mem [logic [15:0]], fq [int];
   int          n_errors = 0, n_checks = 0, n_fwd = 0, n_ers = 0, n, k;
   localparam sacu_byte_t DA = 8'h16;
   sacu_top #(.BLK_DEPTH(128)) sacu_top_i (.mclk_i(mclk_i), .rst_i(rst_i),
      .s_axi_awaddr_i(awa), .s_axi_awvalid_i(awv), .s_axi_awready_o(awr),
      .s_axi_wdata_i(wd), .s_axi_wstrb_i(wd[3:0] | 4'h1), .s_axi_wvalid_i(wv),
      .s_axi_wready_o(wry), .s_axi_bresp_o(br), .s_axi_bvalid_o(bv), .s_axi_bready_i(bry),
      .s_axi_araddr_i(ara), .s_axi_arvalid_i(arv), .s_axi_arready_o(arr),
      .s_axi_rdata_o(rd), .s_axi_rresp_o(rr), .s_axi_rvalid_o(rv), .s_axi_rready_i(rry),
      .smb_start_i(st), .smb_stop_i(sp), .smb_rx_valid_i(rxv), .smb_rx_byte_i(rxb),
      .smb_ack_o(ack), .smb_tx_req_i(txr), .smb_tx_byte_o(txb), .fwd_valid_o(fv),
      .fwd_byte_o(fb), .cpu_sleep_i(sleep), .cpu_halt_o(halt), .erase_o(ers),
      .short_sense_pin_i(strap), .mem_addr_o(ma), .mem_wdata_o(wd8), .mem_we_o(we),
      .mem_rdata_i(rdat), .parallel_byte_port_i(pin), .parallel_byte_port_o(pout),
      .parallel_byte_port_oe_n_o(oen), .write_strobe_i(wrs), .read_strobe_i(rds),
      .addr_byte_select_i(sel), .addr_latch_strobe_i(ale));
   sacu_host host_i (.clk_i(mclk_i), .ack_i(ack), .tx_i(txb), .start_o(st), .stop_o(sp),
      .rxv_o(rxv), .rxb_o(rxb), .txr_o(txr));
   initial begin
      forever #5 mclk_i = ~mclk_i;
   end
   always @(posedge mclk_i) begin
      rdat <= mem.exists(ma) ? mem[ma] : 8'h00;
      if (we) mem[ma] = wd8;
      if (fv) fq[n_fwd] = fb;
      if (fv) n_fwd++;
      if (ers) n_ers++;
   end
   function automatic logic [7:0] rnd();
      xs ^= xs << 13;
      xs ^= xs >> 17;
      xs ^= xs << 5;
      return xs[7:0];
   endfunction : rnd
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      n_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("ERROR %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk
   task automatic end_sim();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : end_sim
   task automatic do_reset(input logic s);
      @(posedge mclk_i);
      {rst_i, strap} <= {1'b1, s};
      repeat (12) @(posedge mclk_i);
      rst_i <= 1'b0;
      repeat (5) @(posedge mclk_i);
   endtask : do_reset
   task automatic ax(input logic w, input logic [7:0] a, input logic [31:0] d,
                     input logic [31:0] ed, input logic [31:0] m, input logic [1:0] er);
      @(posedge mclk_i);
      {awa, ara, wd} <= {a, a, d};
      {awv, wv, bry, arv, rry} <= {w, w, w, !w, !w};
      for (k = 0; k < 40; k++) begin
         @(posedge mclk_i);
         if (awr) awv <= 1'b0;
         if (wry) wv <= 1'b0;
         if (arr) arv <= 1'b0;
         if (w ? bv : rv) break;
      end
      {bry, rry} <= 2'b00;
      if (k == 40) chk(0, 1);
      if (k == 40) end_sim();
      chk(w ? br : rr, er);
      if (!w) chk(rd & m, ed);
   endtask : ax
   task automatic cmd(input sacu_byte_t b[$], input int ok_n, input logic bad);
      host_i.pec = 8'h00;
      host_i.cond(1'b0);
      foreach (b[i]) begin
         host_i.put(b[i]);
         if (ok_n >= 0) chk(host_i.ack_q, i < ok_n);
      end
      host_i.put(host_i.pec ^ {7'h0, bad});
      if (ok_n >= 0) chk(host_i.ack_q, ok_n >= b.size() && !bad);
      host_i.cond(1'b1);
   endtask : cmd
   task automatic rdc(input sacu_byte_t b[$], input sacu_byte_t e[$]);
      sacu_byte_t q, p;
      host_i.pec = 8'h00;
      host_i.cond(1'b0);
      foreach (b[i]) host_i.put(b[i]);
      host_i.cond(1'b0);
      host_i.put(DA | 8'h01);
      foreach (e[i]) begin
         host_i.get(q);
         chk(q, e[i]);
      end
      p = host_i.pec;
      host_i.get(q);
      chk(q, p);
      host_i.cond(1'b1);
   endtask : rdc
   task automatic strobe(input logic [1:0] which, input logic [7:0] v, input logic s);
      @(posedge mclk_i);
      {pin, sel} <= {(which == 2'h2) ? ~v : v, s};
      @(posedge mclk_i);
      {ale, wrs, rds} <= ~(3'b100 >> which);
      repeat (8) @(posedge mclk_i);
      if (which == 2'h2) chk({oen, pout}, {1'b0, v});
      {ale, wrs, rds, pin} <= {3'b111, ~v};
      repeat (8) @(posedge mclk_i);
   endtask : strobe
   initial begin
      sacu_byte_t d0, d1, d2, hi;
      d0 = rnd();
      d1 = rnd();
      d2 = rnd();
      hi = rnd();
      do_reset(1'b1);
      ax(0, 8'h00, 0, 32'h3, 32'hFF, 2'h0);
      ax(0, 8'h0C, 0, 32'h5, 32'hF, 2'h0);
      ax(0, 8'h14, 0, 32'h0, 32'hFFFFFFFF, 2'h2);
      ax(1, 8'h04, 32'h0, 0, 0, 2'h2);
      $display("test regs done");
      cmd('{DA, 8'h00, 8'h00, 8'h01, 8'h23, d0}, 6, 1'b0);
      cmd('{DA, 8'h00, 8'h00, 8'h01, 8'h23, ~d0}, 6, 1'b1);
      chk(mem[16'h0123], d0);
      ax(0, 8'h10, 0, 32'h1, 32'h1, 2'h0);
      ax(1, 8'h10, 32'h1, 0, 0, 2'h0);
      ax(0, 8'h10, 0, 32'h0, 32'h1, 2'h0);
      rdc('{DA, 8'h00, 8'h00, 8'h01, 8'h23}, '{d0});
      host_i.gap = 3;
      cmd('{DA, 8'h00, 8'h82, 8'h02, 8'h10, d1, d2}, 7, 1'b0);
      host_i.gap = 0;
      rdc('{DA, 8'h00, 8'h82, 8'h02, 8'h10}, '{d1, d2});
      $display("test memory done");
      sleep <= 1'b1;
      cmd('{DA, 8'h00, 8'h40, 8'h00}, -1, 1'b0);
      chk(halt, 1'b1);
      sleep <= 1'b0;
      ax(1, 8'h00, 32'h7, 0, 0, 2'h0);
      cmd('{DA, 8'h00, 8'h00, 8'h01, 8'h23, d1}, 2, 1'b0);
      chk(mem[16'h0123], d0);
      n = n_fwd;
      cmd('{DA, 8'h00, 8'h33, 8'h55}, -1, 1'b0);
      chk(n_fwd, n);
      n = n_ers;
      cmd('{DA, 8'h00, 8'h70}, 3, 1'b0);
      chk(n_ers, n + 1);
      ax(0, 8'h00, 0, 32'h3, 32'hFF, 2'h0);
      $display("test lock done");
      cmd('{DA, 8'h00, 8'h20, 8'h0A}, 4, 1'b0);
      cmd('{DA, 8'h00, 8'h40, 8'h05}, 4, 1'b0);
      ax(0, 8'h0C, 0, 32'h8, 32'h8, 2'h0);
      ax(1, 8'h08, 32'h0, 0, 0, 2'h2);
      strobe(2'h0, hi, 1'b1);
      strobe(2'h0, 8'h45, 1'b0);
      strobe(2'h1, d2, 1'b0);
      chk(mem[{hi, 8'h45}], d2);
      strobe(2'h2, d2, 1'b0);
      cmd('{DA, 8'h00, 8'h20, 8'h00}, 4, 1'b0);
      cmd('{DA, 8'h00, 8'h40, 8'h00}, 4, 1'b0);
      chk(halt, 1'b0);
      n = n_fwd;
      cmd('{DA, 8'h00, 8'h33, 8'h55}, -1, 1'b0);
      chk(n_fwd > n, 1'b1);
      chk(fq[n], 8'h33);
      $display("test parallel done");
      do_reset(1'b0);
      n = n_ers;
      cmd('{DA, 8'h00, 8'h70}, 2, 1'b0);
      chk(n_ers, n);
      ax(1, 8'h00, 32'h1, 0, 0, 2'h0);
      n = n_fwd;
      cmd('{DA, 8'h00, 8'h00, 8'h01, 8'h23, d1}, 2, 1'b0);
      chk(n_fwd, n);
      ax(1, 8'h00, 32'h5, 0, 0, 2'h0);
      cmd('{DA, 8'h00, 8'h00, 8'h01, 8'h23, d1}, -1, 1'b0);
      chk(n_fwd > n, 1'b1);
      chk(mem[16'h0123], d0);
      $display("test normal done");
      end_sim();
   end
endmodule : tb
bind sacu_top sacu_sva sacu_sva_i (.mclk_i, .rst_i, .s_axi_arvalid_i, .s_axi_arready_o,
   .s_axi_araddr_i, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
   .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .fwd_valid_o, .cpu_halt_o, .erase_o,
   .short_sense_pin_i, .parallel_byte_port_oe_n_o);
